/* File: design/reerr_pkg.sv */
// Constants for the retimer equalization and edge-rate register bank.
// Assumes a 20 MHz ref_clk, and that pad detectors report strap levels
// as two-bit tri-level codes.
//
// Function
// - Offset 0x08 is a read-only revision byte; writes leave it unchanged
// - Offset 0x09 bits 3:2 select input clock lane equalization
// - 0x09 bits 1:0 select data lane EQ: 0, 2.5, reserved, 5 dB
// - Reset pin rise loads both EQ fields from the tri-level strap
// - Host writes later replace strap-loaded values and steer the outputs
// - Offset 0x0A bits 7:6 set input lane 0 low-power slew
// - 0x0A bits 5:4 set output low-power slew, loaded from config straps
// - 0x0A bits 1:0 set clock lane HS slew, loaded from slew strap
// - Serial port works only while the reset pin is high
// - Reads start at zero or where the last transfer left the pointer, step per acked byte
package reerr_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] REG_REVISION = 8'h08;
  localparam logic [7:0] REG_RX_EQ    = 8'h09;
  localparam logic [7:0] REG_TX_SLEW  = 8'h0A;
  localparam logic [7:0] PTR_RESET    = 8'h00;
  localparam logic [6:0] TARGET_ADDR  = 7'h6C;

  localparam logic [1:0] SLEW_RESET   = 2'h0;
  localparam logic [1:0] EQ_RESET     = 2'h0;

  // ------------------------------------------------------------------
  // Tri-level strap codes and mappings
  // ------------------------------------------------------------------
  localparam logic [1:0] TRI_LOW  = 2'h0;
  localparam logic [1:0] TRI_MID  = 2'h1;
  localparam logic [1:0] TRI_HIGH = 2'h2;

  localparam logic [1:0] EQ_0DB   = 2'h0;
  localparam logic [1:0] EQ_2P5DB = 2'h1;
  localparam logic [1:0] EQ_5DB   = 2'h3;

  localparam logic [1:0] HS_200PS = 2'h0;
  localparam logic [1:0] HS_150PS = 2'h1;
  localparam logic [1:0] HS_250PS = 2'h2;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT   = 4'h7;

  function automatic logic [1:0] reerr_eq_map(input logic [1:0] lvl);
    case (lvl)
      TRI_MID:  reerr_eq_map = EQ_2P5DB;
      TRI_HIGH: reerr_eq_map = EQ_5DB;
      default:  reerr_eq_map = EQ_0DB;
    endcase
  endfunction : reerr_eq_map

  function automatic logic [1:0] reerr_hs_map(input logic [1:0] lvl);
    case (lvl)
      TRI_MID:  reerr_hs_map = HS_150PS;
      TRI_HIGH: reerr_hs_map = HS_250PS;
      default:  reerr_hs_map = HS_200PS;
    endcase
  endfunction : reerr_hs_map

endpackage : reerr_pkg

/* File: design/reerr_sync.sv */
// Two-flop synchroniser bank for pins entering the ref_clk domain.
// Assumes each bit is an independent level; multi-bit codes must be
// stable across the sampling point.
module reerr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        meta[i]     <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        meta[i]     <= async_in[i];
        sync_out[i] <= meta[i];
      end
    end
  end

endmodule : reerr_sync

/* File: design/reerr_regs.sv */
// Equalization and edge-rate registers with a two-wire serial target.
// Assumes the open-drain data pin is resolved outside; SCL up to 100 kHz
// is oversampled by the 20 MHz ref_clk.
module reerr_regs
  import reerr_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h5A  // Arbitrary value
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       active_low_reset_pin,
  input  wire logic       eq_strap_serial_clock_pin,
  input  wire logic [1:0] eq_strap_level,
  input  wire logic [1:0] slew_strap_level,
  input  wire logic [1:0] cfg_lp_slew_code,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  output logic [7:0]      revision_field,
  output logic [1:0]      clock_lane_eq_level,
  output logic [1:0]      data_lane_eq_level,
  output logic [1:0]      input_side_lp_tx_slew,
  output logic [1:0]      output_side_lp_tx_slew,
  output logic [1:0]      clock_lane_hs_tx_slew
);

  // ------------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------------
  logic [8:0] pins_s;
  logic       active_low_reset_pin_s;
  logic       scl_s;
  logic       sda_s;
  logic [1:0] eq_lvl_s;
  logic [1:0] hs_lvl_s;
  logic [1:0] cfg_s;
  logic       active_low_reset_pin_d;
  logic       scl_d;
  logic       sda_d;

  reerr_sync #(.WIDTH(9)) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({active_low_reset_pin, ~eq_strap_serial_clock_pin, ~sda_in,
                eq_strap_level, slew_strap_level, cfg_lp_slew_code}),
    .sync_out (pins_s)
  );

  // SCL and SDA cross inverted so the cleared bank reads as an idle bus
  assign {active_low_reset_pin_s, scl_s, sda_s, eq_lvl_s, hs_lvl_s, cfg_s} = pins_s ^ 9'h0C0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      active_low_reset_pin_d <= 1'b0;
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      active_low_reset_pin_d <= active_low_reset_pin_s;
      scl_d  <= scl_s;
      sda_d  <= sda_s;
    end
  end

  wire active_low_reset_pin_rise = active_low_reset_pin_s & ~active_low_reset_pin_d;
  wire scl_rise  = scl_s & ~scl_d;
  wire scl_fall  = ~scl_s & scl_d;
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

  // ------------------------------------------------------------------
  // Serial target state
  // ------------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_ADDR  = 6'b000010,
    ST_ACK   = 6'b000100,
    ST_WRITE = 6'b001000,
    ST_READ  = 6'b010000,
    ST_RACK  = 6'b100000
  } reerr_state_e;

  reerr_state_e state;
  reerr_state_e next_state;
  logic [7:0]   shift;
  logic [7:0]   tx_shift;
  logic [3:0]   bit_cnt;
  logic [7:0]   ptr;
  logic         is_read;
  logic         have_sub;
  logic         ack_seen;
  logic         drive_low;
  logic [7:0]   rd_byte;

  wire in_addr   = (state == ST_ADDR);
  wire in_ack    = (state == ST_ACK);
  wire in_write  = (state == ST_WRITE);
  wire in_read   = (state == ST_READ);
  wire in_rack   = (state == ST_RACK);
  wire byte_done = scl_fall & (bit_cnt == BITS_PER_BYTE);
  wire addr_hit  = in_addr & byte_done & (shift[7:1] == TARGET_ADDR);
  wire addr_miss = in_addr & byte_done & (shift[7:1] != TARGET_ADDR);
  wire wr_byte_end = in_write & byte_done;
  wire wr_en     = wr_byte_end & have_sub;
  wire [7:0] wr_byte = shift;
  wire load_tx   = scl_fall & ((in_ack & is_read) | (in_rack & ack_seen));
  wire master_ack = in_rack & scl_rise & ~sda_s;
  wire master_nak = in_rack & scl_rise & sda_s;
  wire wr_rx_eq  = wr_en & (ptr == REG_RX_EQ);
  wire wr_slew   = wr_en & (ptr == REG_TX_SLEW);

  // Reserved bits are held as constant zero in the read image
  assign rd_byte =
    (ptr == REG_REVISION) ? REVISION :
    (ptr == REG_RX_EQ)    ? {4'h0, clock_lane_eq_level,
                             data_lane_eq_level} :
    (ptr == REG_TX_SLEW)  ? {input_side_lp_tx_slew,
                             output_side_lp_tx_slew, 2'h0,
                             clock_lane_hs_tx_slew} :
                            8'h00;

  // Port held idle while the reset pin is low
  always_comb begin
    next_state = state;
    if (!active_low_reset_pin_s) begin
      next_state = ST_IDLE;
    end else if (bus_start) begin
      next_state = ST_ADDR;
    end else if (bus_stop || addr_miss || master_nak) begin
      next_state = ST_IDLE;
    end else begin
      case (state)
        ST_ADDR:  if (addr_hit) next_state = ST_ACK;
        ST_WRITE: if (wr_byte_end) next_state = ST_ACK;
        ST_ACK:   if (scl_fall) next_state = is_read ? ST_READ : ST_WRITE;
        ST_READ:  if (scl_fall && bit_cnt == LAST_TX_BIT) next_state = ST_RACK;
        ST_RACK:  if (load_tx) next_state = ST_READ;
        ST_IDLE:  next_state = ST_IDLE;
        default:  next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Receive shifter and bit counter
  always_ff @(posedge ref_clk) begin
    if (rst || bus_start || (in_ack && scl_fall) || load_tx) begin
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
    end else if ((in_addr || in_write) && scl_rise) begin
      bit_cnt <= bit_cnt + 4'h1;
      shift   <= {shift[6:0], sda_s};
    end else if (in_read && scl_fall) begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      is_read  <= 1'b0;
      have_sub <= 1'b0;
      ack_seen <= 1'b0;
    end else begin
      if (addr_hit) begin
        is_read  <= shift[0];
        have_sub <= 1'b0;
      end
      if (wr_byte_end) begin
        have_sub <= 1'b1;
      end
      if (master_ack) begin
        ack_seen <= 1'b1;
      end else if (load_tx || in_read) begin
        ack_seen <= 1'b0;
      end
    end
  end

  // Pointer survives between transfers so a later read resumes there
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ptr <= PTR_RESET;
    end else if (wr_byte_end && !have_sub) begin
      ptr <= wr_byte;
    end else if (wr_en || master_ack) begin
      ptr <= ptr + 8'h01;
    end
  end

  // Transmit side: data changes only while SCL is low
  always_ff @(posedge ref_clk) begin
    if (rst || !active_low_reset_pin_s || bus_start || bus_stop) begin
      drive_low <= 1'b0;
      tx_shift  <= 8'h00;
    end else if (addr_hit || wr_byte_end) begin
      drive_low <= 1'b1;
    end else if (load_tx) begin
      tx_shift  <= rd_byte;
      drive_low <= ~rd_byte[7];
    end else if (in_ack && scl_fall) begin
      drive_low <= 1'b0;
    end else if (in_read && scl_fall) begin
      tx_shift  <= {tx_shift[6:0], 1'b0};
      drive_low <= (bit_cnt == LAST_TX_BIT) ? 1'b0 : ~tx_shift[6];
    end
  end

  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drive_low;

  // ------------------------------------------------------------------
  // Configuration fields
  // ------------------------------------------------------------------
  assign revision_field = REVISION;

  // Strap load wins over a host write landing in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clock_lane_eq_level    <= EQ_RESET;
      data_lane_eq_level     <= EQ_RESET;
      input_side_lp_tx_slew  <= SLEW_RESET;
      output_side_lp_tx_slew <= SLEW_RESET;
      clock_lane_hs_tx_slew  <= SLEW_RESET;
    end else if (active_low_reset_pin_rise) begin
      clock_lane_eq_level    <= reerr_eq_map(eq_lvl_s);
      data_lane_eq_level     <= reerr_eq_map(eq_lvl_s);
      output_side_lp_tx_slew <= cfg_s;
      clock_lane_hs_tx_slew  <= reerr_hs_map(hs_lvl_s);
    end else begin
      if (wr_rx_eq) begin
        clock_lane_eq_level <= wr_byte[3:2];
        data_lane_eq_level  <= wr_byte[1:0];
      end
      if (wr_slew) begin
        input_side_lp_tx_slew  <= wr_byte[7:6];
        output_side_lp_tx_slew <= wr_byte[5:4];
        clock_lane_hs_tx_slew  <= wr_byte[1:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  rev_read_a: assert property (
    load_tx && ptr == REG_REVISION |=> tx_shift == REVISION)
    else $error("revision byte read wrong");
  eq_clk_wr_a: assert property (
    wr_rx_eq && !active_low_reset_pin_rise |=> clock_lane_eq_level == $past(wr_byte[3:2]))
    else $error("clock lane eq write lost");
  eq_data_wr_a: assert property (
    wr_rx_eq && !active_low_reset_pin_rise |=> data_lane_eq_level == $past(wr_byte[1:0]))
    else $error("data lane eq write lost");
  strap_eq_a: assert property (
    active_low_reset_pin_rise && eq_lvl_s == TRI_HIGH |=>
      clock_lane_eq_level == EQ_5DB && data_lane_eq_level == EQ_5DB)
    else $error("eq strap not loaded");
  slew_hold_a: assert property (
    !wr_slew && !active_low_reset_pin_rise |=> $stable(input_side_lp_tx_slew))
    else $error("slew changed without write");
  lp_in_wr_a: assert property (
    wr_slew && !active_low_reset_pin_rise |=> input_side_lp_tx_slew == $past(wr_byte[7:6]))
    else $error("input lp slew write lost");
  lp_out_strap_a: assert property (
    active_low_reset_pin_rise |=> output_side_lp_tx_slew == $past(cfg_s))
    else $error("output lp slew strap not loaded");
  hs_strap_a: assert property (
    active_low_reset_pin_rise && hs_lvl_s == TRI_MID |=> clock_lane_hs_tx_slew == HS_150PS)
    else $error("hs slew strap not loaded");
  reserved_zero_a: assert property (
    load_tx && ptr == REG_TX_SLEW |=> tx_shift[3:2] == 2'h0)
    else $error("reserved bits not zero");

  port_idle_a: assert property (
    !active_low_reset_pin_s |=> state == ST_IDLE ##1 sda_oe_n)
    else $error("port active in reset");

  ptr_step_a: assert property (
    master_ack |=> ptr == $past(ptr) + 8'h01)
    else $error("pointer did not advance");

  write_c: cover property (wr_slew);
  read_c:  cover property (load_tx && ptr == REG_RX_EQ);
  strap_c: cover property (active_low_reset_pin_rise ##[1:1000] addr_hit);

endmodule : reerr_regs

/* File: testbench/reerr_host_model.sv */
// Behavioural two-wire bus master for the register bank's target port.
// Assumes the testbench resolves the data wire with a pull-up.
module reerr_host_model (
  input  wire logic ref_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_rel
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------------
  // Bus phases
  // ------------------------------------------------------------------
  // Quarter bit of 12 clocks keeps each clock phase above 10 clocks
  localparam int Q = 12;
  initial begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : hold
  task automatic start();
    sda_rel <= 1'b1;
    hold(Q);
    scl     <= 1'b1;
    hold(Q);
    sda_rel <= 1'b0;
    hold(Q);
    scl     <= 1'b0;
    hold(Q);
  endtask : start
  task automatic stop();
    sda_rel <= 1'b0;
    hold(Q);
    scl     <= 1'b1;
    hold(Q);
    sda_rel <= 1'b1;
    hold(2 * Q);
  endtask : stop
  // Data held across the whole high phase; sampled in its middle
  task automatic bit_io(input logic b, output logic s);
    sda_rel <= b;
    hold(Q);
    scl     <= 1'b1;
    hold(Q);
    s = sda_line;
    hold(Q);
    scl     <= 1'b0;
    hold(Q);
  endtask : bit_io
  task automatic xfer(input logic [7:0] d, input logic mack,
                      output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
      q[i] = s;
    end
    bit_io(mack, s);
    ack = ~s;
  endtask : xfer
endmodule : reerr_host_model

/* File: testbench/testbench.sv */
// Self-checking bench for the equalization and edge-rate register bank.
// Assumes reerr_host_model as bus master and a pulled-up data wire.
`define CHK(nm, e, g) \
  begin \
    checks++; \
    if (32'(g) !== 32'(e)) begin \
      n_errors++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, 32'(e), 32'(g)); \
    end \
  end
module testbench
  import reerr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] REV = 8'hC3;  // Arbitrary revision value
  logic        ref_clk, rst, pin, scl, sda_rel, sda_out, sda_oe_n;
  logic [1:0]  eq_lv, sl_lv, cfg, ceq, deq, ilp, olp, hs;
  logic [7:0]  rev;
  logic [31:0] seed;
  int          n_errors, checks, mc, md, mi, mo, mh, mp;
  wire         sda_line = sda_rel & (sda_oe_n | sda_out);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  reerr_regs #(.REVISION(REV)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .active_low_reset_pin(pin),
    .eq_strap_serial_clock_pin(scl), .eq_strap_level(eq_lv),
    .slew_strap_level(sl_lv), .cfg_lp_slew_code(cfg), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .revision_field(rev),
    .clock_lane_eq_level(ceq), .data_lane_eq_level(deq),
    .input_side_lp_tx_slew(ilp), .output_side_lp_tx_slew(olp),
    .clock_lane_hs_tx_slew(hs));
  reerr_host_model host_u (.ref_clk(ref_clk), .sda_line(sda_line),
                           .scl(scl), .sda_rel(sda_rel));
  // ------------------------------------------------------------------
  // Reference model
  // ------------------------------------------------------------------
  function automatic int rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed[7:0]);
  endfunction : rnd8
  function automatic int mread(input int p);
    case (p)
      8:       return int'(REV);
      9:       return mc * 4 + md;
      10:      return mi * 64 + mo * 16 + mh;
      default: return 0;
    endcase
  endfunction : mread
  // Reserved bits are simply dropped by the field split
  task automatic mwrite(input int p, input int d);
    if (p == 9) begin
      mc = d / 4 % 4;
      md = d % 4;
    end
    if (p == 10) begin
      mi = d / 64;
      mo = d / 16 % 4;
      mh = d % 4;
    end
  endtask : mwrite
  task automatic mload();
    mc = (eq_lv == 2'h1) ? 1 : (eq_lv == 2'h2) ? 3 : 0;
    md = mc;
    mh = (sl_lv == 2'h1 || sl_lv == 2'h2) ? int'(sl_lv) : 0;
    mo = int'(cfg);
  endtask : mload
  // ------------------------------------------------------------------
  // Checks and bus access
  // ------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic chk_fields();
    `CHK("revision", REV, rev);
    `CHK("clk_eq", mc, ceq);
    `CHK("data_eq", md, deq);
    `CHK("in_lp_slew", mi, ilp);
    `CHK("out_lp_slew", mo, olp);
    `CHK("hs_slew", mh, hs);
  endtask : chk_fields
  task automatic wr(input logic [6:0] a, input logic exp, input int sub,
                    input int d[$]);
    logic [7:0] q;
    logic       k;
    host_u.start();
    host_u.xfer({a, 1'b0}, 1'b1, q, k);
    `CHK("addr_ack", exp, k);
    if (k === 1'b1) begin
      host_u.xfer(8'(sub), 1'b1, q, k);
      mp = sub;
      foreach (d[i]) begin
        host_u.xfer(8'(d[i]), 1'b1, q, k);
        `CHK("data_ack", 1, k);
        mwrite(mp, d[i]);
        mp++;
      end
    end
    host_u.stop();
  endtask : wr
  task automatic rd(input int n);
    logic [7:0] q;
    logic       k;
    host_u.start();
    host_u.xfer({TARGET_ADDR, 1'b1}, 1'b1, q, k);
    for (int i = 0; i < n; i++) begin
      host_u.xfer(8'hFF, i == n - 1, q, k);
      `CHK("read_byte", mread(mp), q);
      if (i < n - 1) mp++;
    end
    host_u.stop();
  endtask : rd
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    int dq[$];
    seed = 32'h000100F5;
    rst = 1'b1;
    pin = 1'b0;
    eq_lv = 2'h0;
    sl_lv = 2'h0;
    cfg = 2'h0;
    cyc(20);
    rst <= 1'b0;
    cyc(5);
    chk_fields();
    $display("test reset done");
    for (int lv = 0; lv < 4; lv++) begin
      pin <= 1'b0;
      eq_lv <= 2'(lv);
      sl_lv <= 2'(3 - lv);
      cfg <= 2'(rnd8());
      cyc(5);
      pin <= 1'b1;
      cyc(12);
      mload();
      chk_fields();
    end
    $display("test strap load done");
    rd(11);
    $display("test read from zero done");
    for (int r = 0; r < 3; r++) begin
      dq = {rnd8(), rnd8(), rnd8()};
      wr(TARGET_ADDR, 1'b1, 8, dq);
      cyc(4);
      chk_fields();
      dq.delete();
      wr(TARGET_ADDR, 1'b1, 8, dq);
      rd(3);
    end
    $display("test write readback done");
    dq = {rnd8()};
    wr(7'h6D, 1'b0, 9, dq);
    pin <= 1'b0;
    eq_lv <= 2'h2;
    sl_lv <= 2'h1;
    cfg <= 2'(rnd8());
    cyc(6);
    wr(TARGET_ADDR, 1'b0, 9, dq);
    pin <= 1'b1;
    cyc(12);
    mload();
    chk_fields();
    wr(TARGET_ADDR, 1'b1, 10, dq);
    cyc(4);
    chk_fields();
    $display("test refusal and reload done");
    summarize();
  end
  initial begin
    cyc(60000);
    n_errors++;
    $display("[FAIL] watchdog expected finish seen hang");
    summarize();
  end
endmodule : testbench
